// ==== rtl/bsc_sideband.sv ====
// Sideband, power-state and reset sequencing logic of a bus agent.
// Assumes all inputs arrive on the bus clock except the async pins,
// which are synchronised here; wire-OR lines use separate in/out/oe.
//
// What this block does
// - Controller disabled: pin 0 is maskable request, pin 1 nonmaskable; async inputs.
// - After reset the local interrupt controller is enabled (local interrupt mode).
// - Bus lock held from first to last transaction of a locked sequence.
// - Machine-check line is wire-OR; drive and sample on designated edges only.
// - Machine-check assertion: enable, with internal fault, by requester, on bus error.
// - Reset returns to known state and invalidates caches without write back.
// - On reset all bus outputs are released within two bus clocks.
// - Configuration bus signals are latched as reset goes inactive.
// - Status 000 expects parity high and reports no error.
// - Sleep request in Stop-Grant enters Sleep; only the PLL runs.
// - In Sleep interrupts are ignored.
// - Sleep request released: back to Stop-Grant, bus clock restarts, core clock stays off until Run.
// - Socket-present output pulled low to show the device is installed.
// - Only the bus owner drives the five request command lines.
// - Open-drain thermal alert output tied to the thermal sensor.
// - Thermal-throttle output asserted while the thermal control circuit is active.
// - Stop-clock request enters Stop-Grant, the only path into Sleep.
`timescale 1ns/10ps
module bsc_sideband
   import bsc_pkg::*;
(
   // Clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_bus_reset_n,
   input  wire logic               i_supplies_stable,
   // Local interrupt pins and controller mode
   input  wire logic [1:0]         i_local_irq_pins,
   input  wire logic               i_local_int_controller_dis,
   // Bus lock and request command
   input  wire logic               i_lock_seq_start,
   input  wire logic               i_lock_seq_end,
   input  wire logic               i_bus_owner,
   input  wire logic [4:0]         i_req_cmd,
   // Machine check
   input  wire bsc_mce_cfg_t       i_mce_cfg,
   input  wire logic               i_internal_fault,
   input  wire logic               i_req_saw_error,
   input  wire logic               i_bus_error_seen,
   input  wire logic               i_mce_edge,
   input  wire logic               i_machine_check_fault_n,
   // Response status and parity
   input  wire logic [2:0]         i_response_status_n,
   input  wire logic               i_response_parity_n,
   // Power state requests
   input  wire logic               i_stop_clock_req_n,
   input  wire logic               i_sleep_req_n,
   // Thermal
   input  wire logic               i_thermal_control_circuit,
   input  wire logic               i_sensor_alert,
   // Power-on configuration source
   input  wire logic [CFG_W-1:0]   i_cfg_pins,
   // Interrupt results
   output logic                    o_maskable_irq_req,
   output logic                    o_nmi_req,
   output logic [1:0]              o_local_irq,
   // Bus lock and request command
   output logic                    o_lock_n,
   output logic [4:0]              o_req_cmd_n,
   output logic                    o_req_cmd_oe,
   // Machine check wire-OR pin
   output logic                    o_machine_check_fault_n,
   output logic                    o_machine_check_fault_oe,
   output logic                    o_mce_seen,
   output logic                    o_internal_fault_n,
   // Response parity
   output logic                    o_resp_parity_err,
   // Power state and clocks
   output bsc_clk_ctl_t            o_clk_ctl,
   output logic                    o_in_stop_grant,
   output logic                    o_in_sleep,
   output logic                    o_cache_invalidate,
   // Configuration and presence
   output logic [CFG_W-1:0]        o_cfg_latched,
   output logic                    o_socket_present_n,
   // Thermal
   output logic                    o_thermal_alert_n,
   output logic                    o_thermal_alert_oe,
   output logic                    o_thermal_throttle_n
);

   // ***********************************************************
   // Synchronisers
   // ***********************************************************
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync_q1;
   logic [NSYNC-1:0] sync_q2;
   logic [NSYNC-1:0] next_q1;
   logic [NSYNC-1:0] next_q2;

   // Gather async sources: irq pins, sleep, stop clock, reset
   assign async_in = {i_bus_reset_n, i_stop_clock_req_n, i_sleep_req_n,
                      i_local_irq_pins};

   // Two flops per bit; first stage read only by the second
   generate
      for (genvar g = 0; g < NSYNC; g++) begin : g_sync
         always_comb begin
            next_q1[g] = async_in[g];
            next_q2[g] = sync_q1[g];
         end
      end
   endgenerate

   // Register synchroniser stages
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_q1 <= {NSYNC{1'b1}};
         sync_q2 <= {NSYNC{1'b1}};
      end else begin
         sync_q1 <= next_q1;
         sync_q2 <= next_q2;
      end
   end

   logic [1:0] irq_s;
   logic       sleep_req_s;
   logic       stop_req_s;
   logic       bus_rst_s;
   assign irq_s       = sync_q2[1:0];
   assign sleep_req_s = !sync_q2[2];
   assign stop_req_s  = !sync_q2[3];
   assign bus_rst_s   = !sync_q2[4];

   // ***********************************************************
   // Reset sequencing and control state
   // ***********************************************************
   logic         rst_act;
   logic         rst_prev;
   logic         next_rst_prev;
   logic [1:0]   drain_cnt;
   logic [1:0]   next_drain_cnt;
   logic         quiet;
   logic [CFG_W-1:0] next_cfg;
   logic         next_inval;

   // Bus reset or supplies not stable both hold the block in reset
   assign rst_act = bus_rst_s || !i_supplies_stable;
   assign quiet   = rst_act && (drain_cnt == 2'(RESET_DRAIN_CLK - 1));

   // Drain counter, config latch on release, cache invalidate pulse
   always_comb begin
      next_rst_prev  = rst_act;
      next_drain_cnt = drain_cnt;
      next_cfg       = o_cfg_latched;
      next_inval     = 1'b0;
      if (rst_act) begin
         if (drain_cnt != 2'(RESET_DRAIN_CLK - 1)) begin
            next_drain_cnt = drain_cnt + 2'h1;
         end
         next_inval = !rst_prev;
      end else begin
         next_drain_cnt = 2'h0;
      end
      if (rst_prev && !rst_act) begin
         next_cfg = i_cfg_pins;
      end
   end

   // Register reset sequencing
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_prev           <= 1'b1;
         drain_cnt          <= 2'h0;
         o_cfg_latched      <= '0;
         o_cache_invalidate <= 1'b0;
      end else begin
         rst_prev           <= next_rst_prev;
         drain_cnt          <= next_drain_cnt;
         o_cfg_latched      <= next_cfg;
         o_cache_invalidate <= next_inval;
      end
   end

   // ***********************************************************
   // Power state machine
   // ***********************************************************
   bsc_pstate_t  pstate;
   bsc_pstate_t  next_pstate;
   bsc_clk_ctl_t next_clk;

   // Run, Stop-Grant, Sleep transitions
   always_comb begin
      next_pstate = pstate;
      case (pstate)
         PS_RUN: begin
            if (stop_req_s) next_pstate = PS_STOP_GRANT;
         end
         PS_STOP_GRANT: begin
            if (sleep_req_s) next_pstate = PS_SLEEP;
            else if (!stop_req_s) next_pstate = PS_RUN;
         end
         PS_SLEEP: begin
            if (!sleep_req_s) next_pstate = PS_STOP_GRANT;
         end
         default: next_pstate = PS_RUN;
      endcase
      if (rst_act) next_pstate = PS_RUN;
      next_clk.pll_only    = (next_pstate == PS_SLEEP);
      next_clk.bus_clk_en  = (next_pstate != PS_SLEEP);
      next_clk.core_clk_en = (next_pstate == PS_RUN);
   end

   // Register power state
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pstate    <= PS_RUN;
         o_clk_ctl <= '{core_clk_en: 1'b1, bus_clk_en: 1'b1, pll_only: 1'b0};
      end else begin
         pstate    <= next_pstate;
         o_clk_ctl <= next_clk;
      end
   end

   // ***********************************************************
   // Interrupts, lock, machine check, parity, thermal
   // ***********************************************************
   logic         asleep;
   logic         next_maskable_irq_req;
   logic         next_nmi;
   logic [1:0]   next_lint;
   logic         lock_held;
   logic         next_lock_held;
   logic         next_mce_drv;
   logic         mce_drv;
   logic         next_mce_seen;
   logic         next_perr;
   logic         next_ifault;
   logic         ifault;
   logic         next_req_oe;
   logic [4:0]   next_req_n;

   assign asleep = (pstate == PS_SLEEP);

   // Sideband next values
   always_comb begin
      // Interrupts route by controller mode; ignored in Sleep
      next_maskable_irq_req = 1'b0;
      next_nmi  = 1'b0;
      next_lint = 2'h0;
      if (!asleep && !rst_act) begin
         if (i_local_int_controller_dis) begin
            next_maskable_irq_req = irq_s[0];
            next_nmi  = irq_s[1];
         end else begin
            next_lint = irq_s;
         end
      end
      // Lock held from first start to last end
      next_lock_held = lock_held;
      if (i_lock_seq_start) next_lock_held = 1'b1;
      else if (i_lock_seq_end) next_lock_held = 1'b0;
      // Internal fault is sticky until reset
      next_ifault = ifault || i_internal_fault;
      // Machine-check drive, changed only on designated edges or cleared by reset
      next_mce_drv = mce_drv;
      if (i_mce_edge) begin
         next_mce_drv = i_bus_error_seen
                     || (i_mce_cfg.enable && i_mce_cfg.with_internal && i_internal_fault)
                     || (i_mce_cfg.enable && i_mce_cfg.by_requester && i_req_saw_error);
      end
      next_mce_seen = o_mce_seen;
      if (i_mce_edge) next_mce_seen = !i_machine_check_fault_n;
      // Parity: idle status expects high and never flags
      next_perr = 1'b0;
      if (i_response_status_n != ~RS_IDLE) begin
         next_perr = (^(~i_response_status_n)) != (!i_response_parity_n);
      end
      // Request command only while owning the bus
      next_req_oe = i_bus_owner;
      next_req_n  = i_bus_owner ? ~i_req_cmd : 5'h1f;
      // Reset releases every bus output
      if (rst_act) begin
         next_lock_held = 1'b0;
         next_mce_drv   = 1'b0;
         next_req_oe    = 1'b0;
         next_req_n     = 5'h1f;
         next_ifault    = 1'b0;
         next_perr      = 1'b0;
      end
   end

   // Register sideband outputs
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_maskable_irq_req       <= 1'b0;
         o_nmi_req                <= 1'b0;
         o_local_irq              <= 2'h0;
         lock_held                <= 1'b0;
         o_lock_n                 <= 1'b1;
         mce_drv                  <= 1'b0;
         o_machine_check_fault_n  <= 1'b1;
         o_machine_check_fault_oe <= 1'b0;
         o_mce_seen               <= 1'b0;
         ifault                   <= 1'b0;
         o_internal_fault_n       <= 1'b1;
         o_resp_parity_err        <= 1'b0;
         o_req_cmd_n              <= 5'h1f;
         o_req_cmd_oe             <= 1'b0;
         o_in_stop_grant          <= 1'b0;
         o_in_sleep               <= 1'b0;
         o_socket_present_n       <= 1'b0;
         o_thermal_alert_n        <= 1'b1;
         o_thermal_alert_oe       <= 1'b0;
         o_thermal_throttle_n     <= 1'b1;
      end else begin
         o_maskable_irq_req       <= next_maskable_irq_req;
         o_nmi_req                <= next_nmi;
         o_local_irq              <= next_lint;
         lock_held                <= next_lock_held;
         o_lock_n                 <= !next_lock_held;
         mce_drv                  <= next_mce_drv;
         o_machine_check_fault_n  <= 1'b0;              // Open drain pulls low only
         o_machine_check_fault_oe <= next_mce_drv;
         o_mce_seen               <= next_mce_seen;
         ifault                   <= next_ifault;
         o_internal_fault_n       <= !next_ifault;
         o_resp_parity_err        <= next_perr;
         o_req_cmd_n              <= next_req_n;
         o_req_cmd_oe             <= next_req_oe;
         o_in_stop_grant          <= (next_pstate == PS_STOP_GRANT);
         o_in_sleep               <= (next_pstate == PS_SLEEP);
         o_socket_present_n       <= 1'b0;
         o_thermal_alert_n        <= 1'b0;
         o_thermal_alert_oe       <= i_sensor_alert;
         o_thermal_throttle_n     <= !i_thermal_control_circuit;
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   a_reset_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(rst_act) |-> ##[1:3] (!o_req_cmd_oe && !o_machine_check_fault_oe && o_lock_n))
      else $error("bus outputs not released after reset");
   a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      quiet |-> (!o_req_cmd_oe && !o_machine_check_fault_oe && o_lock_n))
      else $error("bus outputs driven late in reset");
   a_sleep_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pstate == PS_STOP_GRANT && sleep_req_s && !rst_act) |=> (o_in_sleep && o_clk_ctl.pll_only))
      else $error("sleep not entered from stop grant");
   a_sleep_only_sg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pstate == PS_RUN) |=> (pstate != PS_SLEEP))
      else $error("sleep entered from run");
   a_sleep_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (asleep && !sleep_req_s && !rst_act) |=> (o_in_stop_grant && o_clk_ctl.bus_clk_en))
      else $error("sleep exit failed");
   a_sleep_no_irq: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      asleep |=> (o_local_irq == 2'h0 && !o_nmi_req && !o_maskable_irq_req))
      else $error("interrupt passed in sleep");
   a_idle_parity: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_response_status_n == 3'h7) |=> !o_resp_parity_err)
      else $error("parity error on idle status");
   a_lock_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ((i_lock_seq_start || (!o_lock_n && !i_lock_seq_end)) && !rst_act) |=> !o_lock_n)
      else $error("lock dropped inside sequence");
   a_cfg_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (rst_prev && !rst_act) |=> (o_cfg_latched == $past(i_cfg_pins)))
      else $error("config not latched at reset release");
   a_mce_edges: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!$past(i_mce_edge) && !rst_act && !$past(rst_act)) |-> $stable(o_machine_check_fault_oe))
      else $error("machine check changed off edge");
   a_throttle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_thermal_control_circuit |=> !o_thermal_throttle_n)
      else $error("throttle not asserted");

endmodule // bsc_sideband

// ==== rtl/bsc_pkg.sv ====
// Package for the bus sideband, power and reset control block.
// Assumes one 100 MHz bus clock; no software-visible registers.
package bsc_pkg;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS   = 10;
   localparam int RESET_DRAIN_CLK = 2;   // Outputs released within two clocks

   // ***********************************************************
   // Response status encodings
   // ***********************************************************
   localparam logic [2:0] RS_IDLE = 3'h0;

   // ***********************************************************
   // Power-on configuration width
   // ***********************************************************
   localparam int CFG_W = 8;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {
      PS_RUN,
      PS_STOP_GRANT,
      PS_SLEEP
   } bsc_pstate_t;

   // Machine-check assertion options
   typedef struct packed {
      logic enable;        // Enable for the internal and requester options; bus error asserts without it
      logic with_internal; // Assert with the internal fault
      logic by_requester;  // Requester asserts after seeing an error
   } bsc_mce_cfg_t;

   // Clock gating view of the power state
   typedef struct packed {
      logic core_clk_en;
      logic bus_clk_en;
      logic pll_only;
   } bsc_clk_ctl_t;

endpackage : bsc_pkg

// ==== verif/bsc_far_agent.sv ====
// Far-side bus agents: response agent, peer machine-check driver, priority agent.
// Assumes the block's bus clock and reset; the bench commands every action.
`timescale 1ns/10ps
module bsc_far_agent (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   // Commands from the bench
   input  wire logic [2:0] i_rs_val,
   input  wire logic       i_bad_parity,
   input  wire logic       i_peer_mce,
   input  wire logic       i_prio_want,
   // Device pins seen
   input  wire logic       i_dev_mce_oe,
   input  wire logic       i_lock_n,
   // Wire levels and grant
   output logic [2:0]      o_response_status_n,
   output logic            o_response_parity_n,
   output logic            o_machine_check_fault_n,
   output logic            o_prio_granted
);
   // Status lines low when asserted; parity high on an even count of lows
   always_comb begin
      o_response_status_n = ~i_rs_val;
      o_response_parity_n = ~(^i_rs_val) ^ i_bad_parity;
   end

   // Wire-OR line with pull-up; any driver pulls it low
   assign o_machine_check_fault_n = ~(i_dev_mce_oe | i_peer_mce);

   // Priority agent waits for lock released before taking the bus
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prio_granted <= 1'h0;
      end else begin
         o_prio_granted <= i_prio_want & (o_prio_granted | i_lock_n);
      end
   end
endmodule // bsc_far_agent

// ==== verif/tb_top.sv ====
// Self-checking bench for the sideband, power and reset block.
// Assumes a far-agent model on the bus side; bench drives the rest.
`timescale 1ns/10ps
module tb_top;
   import bsc_pkg::*;
   // ***********************************************************
   // Signals
   // ***********************************************************
   logic                i_ref_clk, i_rst_n, i_bus_reset_n, i_supplies_stable;
   logic [1:0]          i_local_irq_pins, o_local_irq;
   logic                i_local_int_controller_dis, i_lock_seq_start, i_lock_seq_end;
   logic                i_bus_owner, i_internal_fault, i_req_saw_error, i_bus_error_seen;
   logic [4:0]          i_req_cmd, o_req_cmd_n;
   bsc_mce_cfg_t        i_mce_cfg;
   logic                i_mce_edge, i_machine_check_fault_n, i_response_parity_n;
   logic [2:0]          i_response_status_n, rs_val;
   logic                i_stop_clock_req_n, i_sleep_req_n, i_thermal_control_circuit;
   logic                i_sensor_alert, o_maskable_irq_req, o_nmi_req, o_lock_n, o_req_cmd_oe;
   logic [CFG_W-1:0]    i_cfg_pins, o_cfg_latched;
   logic                o_machine_check_fault_n, o_machine_check_fault_oe, o_mce_seen;
   logic                o_internal_fault_n, o_resp_parity_err, o_in_stop_grant, o_in_sleep;
   bsc_clk_ctl_t        o_clk_ctl;
   logic                o_cache_invalidate, o_socket_present_n, o_thermal_alert_n;
   logic                o_thermal_alert_oe, o_thermal_throttle_n;
   logic                bad_parity, peer_mce, prio_want, prio_granted;
   int                  err_count, cmp_count, perr_n, inv_n;

   bsc_sideband DUT (.i_ref_clk, .i_rst_n, .i_bus_reset_n, .i_supplies_stable,
      .i_local_irq_pins, .i_local_int_controller_dis, .i_lock_seq_start,
      .i_lock_seq_end, .i_bus_owner, .i_req_cmd, .i_mce_cfg, .i_internal_fault,
      .i_req_saw_error, .i_bus_error_seen, .i_mce_edge, .i_machine_check_fault_n,
      .i_response_status_n, .i_response_parity_n, .i_stop_clock_req_n, .i_sleep_req_n,
      .i_thermal_control_circuit, .i_sensor_alert, .i_cfg_pins, .o_maskable_irq_req,
      .o_nmi_req, .o_local_irq, .o_lock_n, .o_req_cmd_n, .o_req_cmd_oe,
      .o_machine_check_fault_n, .o_machine_check_fault_oe, .o_mce_seen,
      .o_internal_fault_n, .o_resp_parity_err, .o_clk_ctl, .o_in_stop_grant,
      .o_in_sleep, .o_cache_invalidate, .o_cfg_latched, .o_socket_present_n,
      .o_thermal_alert_n, .o_thermal_alert_oe, .o_thermal_throttle_n);

   bsc_far_agent u_far (.i_ref_clk, .i_rst_n, .i_rs_val(rs_val), .i_bad_parity(bad_parity),
      .i_peer_mce(peer_mce), .i_prio_want(prio_want), .i_dev_mce_oe(o_machine_check_fault_oe),
      .i_lock_n(o_lock_n), .o_response_status_n(i_response_status_n),
      .o_response_parity_n(i_response_parity_n),
      .o_machine_check_fault_n(i_machine_check_fault_n), .o_prio_granted(prio_granted));

   // ***********************************************************
   // Clock, pulse counters and helpers
   // ***********************************************************
   always #5 i_ref_clk = ~i_ref_clk;

   // Count one-cycle pulses so no edge is missed
   always @(posedge i_ref_clk) begin
      if (o_resp_parity_err === 1'h1) perr_n++;
      if (o_cache_invalidate === 1'h1) inv_n++;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask

   // One designated drive/sample edge for the wire-OR line
   task automatic mce_edge();
      @(posedge i_ref_clk) i_mce_edge <= 1'h1;
      @(posedge i_ref_clk) i_mce_edge <= 1'h0;
      cyc(2);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_idle();
      @(posedge i_ref_clk) i_local_irq_pins <= 2'h3;
      cyc(5);
      chk({o_lock_n, o_req_cmd_oe, o_socket_present_n}, 3'h4);
      chk(o_clk_ctl, 3'h6);
      chk({o_nmi_req, o_maskable_irq_req, o_local_irq}, 4'h3);
      @(posedge i_ref_clk) i_local_int_controller_dis <= 1'h1;
      i_local_irq_pins <= 2'h1;
      cyc(5);
      chk({o_nmi_req, o_maskable_irq_req}, 2'h1);
      @(posedge i_ref_clk) i_local_irq_pins <= 2'h2;
      cyc(5);
      chk({o_nmi_req, o_maskable_irq_req}, 2'h2);
      @(posedge i_ref_clk) i_local_irq_pins <= 2'h0;
      i_local_int_controller_dis <= 1'h0;
   endtask

   task automatic t_lock_cmd();
      @(posedge i_ref_clk) i_lock_seq_start <= 1'h1;
      @(posedge i_ref_clk) i_lock_seq_start <= 1'h0;
      prio_want <= 1'h1;
      i_bus_owner <= 1'h1;
      i_req_cmd <= 5'h13;
      cyc(4);
      chk({o_lock_n, prio_granted}, 2'h0);
      chk({o_req_cmd_oe, o_req_cmd_n}, 6'h2c);
      @(posedge i_ref_clk) i_lock_seq_end <= 1'h1;
      i_bus_owner <= 1'h0;
      @(posedge i_ref_clk) i_lock_seq_end <= 1'h0;
      cyc(3);
      chk({o_lock_n, prio_granted, o_req_cmd_oe}, 3'h6);
      @(posedge i_ref_clk) prio_want <= 1'h0;
   endtask

   task automatic t_mce();
      @(posedge i_ref_clk) i_mce_cfg <= 3'h0;
      i_req_saw_error <= 1'h1;
      mce_edge();
      chk(o_machine_check_fault_oe, 1'h0);
      @(posedge i_ref_clk) i_mce_cfg <= 3'h5;
      cyc(3);
      chk(o_machine_check_fault_oe, 1'h0);
      mce_edge();
      chk(o_machine_check_fault_oe, 1'h1);
      @(posedge i_ref_clk) i_req_saw_error <= 1'h0;
      i_mce_cfg <= 3'h0;
      i_bus_error_seen <= 1'h1;
      mce_edge();
      chk(o_machine_check_fault_oe, 1'h1);
      @(posedge i_ref_clk) i_bus_error_seen <= 1'h0;
      mce_edge();
      chk(o_machine_check_fault_oe, 1'h0);
      @(posedge i_ref_clk) peer_mce <= 1'h1;
      mce_edge();
      chk(o_mce_seen, 1'h1);
      @(posedge i_ref_clk) peer_mce <= 1'h0;
      mce_edge();
      chk(o_mce_seen, 1'h0);
      @(posedge i_ref_clk) i_mce_cfg <= 3'h6;
      i_internal_fault <= 1'h1;
      mce_edge();
      chk({o_machine_check_fault_oe, o_machine_check_fault_n, o_internal_fault_n}, 3'h4);
      @(posedge i_ref_clk) i_internal_fault <= 1'h0;
      cyc(3);
      chk(o_internal_fault_n, 1'h0);
   endtask

   task automatic t_parity();
      perr_n = 0;
      for (int v = 0; v < 8; v++) begin
         @(posedge i_ref_clk) rs_val <= v[2:0];
      end
      @(posedge i_ref_clk) rs_val <= 3'h0;
      cyc(4);
      chk(perr_n[7:0], 8'h0);
      @(posedge i_ref_clk) rs_val <= 3'h5;
      bad_parity <= 1'h1;
      @(posedge i_ref_clk) rs_val <= 3'h0; // Idle status with low parity
      @(posedge i_ref_clk) bad_parity <= 1'h0;
      cyc(4);
      chk(perr_n[7:0], 8'h1);
   endtask

   task automatic t_power();
      @(posedge i_ref_clk) i_sleep_req_n <= 1'h0;
      cyc(5);
      chk({o_in_sleep, o_in_stop_grant, o_clk_ctl}, 5'h06);
      @(posedge i_ref_clk) i_sleep_req_n <= 1'h1;
      i_stop_clock_req_n <= 1'h0;
      cyc(5);
      chk({o_in_sleep, o_in_stop_grant, o_clk_ctl}, 5'h0a);
      @(posedge i_ref_clk) i_sleep_req_n <= 1'h0;
      cyc(5);
      chk({o_in_sleep, o_in_stop_grant, o_clk_ctl}, 5'h11);
      @(posedge i_ref_clk) i_local_irq_pins <= 2'h3;
      cyc(5);
      chk(o_local_irq, 2'h0);
      @(posedge i_ref_clk) i_sleep_req_n <= 1'h1;
      cyc(5);
      chk({o_in_sleep, o_in_stop_grant, o_clk_ctl}, 5'h0a);
      chk(o_local_irq, 2'h3);
      @(posedge i_ref_clk) i_stop_clock_req_n <= 1'h1;
      i_local_irq_pins <= 2'h0;
      cyc(5);
      chk({o_in_sleep, o_in_stop_grant, o_clk_ctl}, 5'h06);
   endtask

   task automatic t_thermal();
      @(posedge i_ref_clk) i_thermal_control_circuit <= 1'h1;
      i_sensor_alert <= 1'h1;
      cyc(3);
      chk({o_thermal_throttle_n, o_thermal_alert_n, o_thermal_alert_oe}, 3'h1);
      @(posedge i_ref_clk) i_thermal_control_circuit <= 1'h0;
      i_sensor_alert <= 1'h0;
      cyc(3);
      chk({o_thermal_throttle_n, o_thermal_alert_oe}, 2'h2);
   endtask

   task automatic t_bus_reset();
      @(posedge i_ref_clk) i_lock_seq_start <= 1'h1;
      i_bus_owner <= 1'h1;
      i_cfg_pins <= 8'ha5;
      @(posedge i_ref_clk) i_lock_seq_start <= 1'h0;
      inv_n = 0;
      @(posedge i_ref_clk) i_bus_reset_n <= 1'h0;
      cyc(3);
      chk({o_lock_n, o_req_cmd_oe, o_machine_check_fault_oe}, 3'h4);
      cyc(2);
      chk(inv_n[7:0], 8'h1);
      @(posedge i_ref_clk) i_bus_reset_n <= 1'h1;
      i_bus_owner <= 1'h0;
      cyc(5);
      chk(o_cfg_latched, 8'ha5);
      chk(o_internal_fault_n, 1'h1);
      @(posedge i_ref_clk) i_cfg_pins <= 8'h3c;
      cyc(3);
      chk(o_cfg_latched, 8'ha5);
      @(posedge i_ref_clk) i_supplies_stable <= 1'h0;
      cyc(2);
      chk(inv_n[7:0], 8'h2);
      @(posedge i_ref_clk) i_supplies_stable <= 1'h1;
      cyc(3);
      chk(o_cfg_latched, 8'h3c);
   endtask

   // ***********************************************************
   // Main sequence and watchdog
   // ***********************************************************
   initial begin
      {i_ref_clk, i_rst_n, i_lock_seq_start, i_lock_seq_end, i_bus_owner} = '0;
      {i_local_irq_pins, i_local_int_controller_dis, i_req_cmd, i_mce_cfg} = '0;
      {i_internal_fault, i_req_saw_error, i_bus_error_seen, i_mce_edge} = '0;
      {i_thermal_control_circuit, i_sensor_alert, rs_val, bad_parity} = '0;
      {peer_mce, prio_want, err_count, cmp_count, perr_n, inv_n} = '0;
      {i_bus_reset_n, i_supplies_stable, i_stop_clock_req_n, i_sleep_req_n} = 4'hf;
      i_cfg_pins = 8'h5a;
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      cyc(4);
      t_idle();
      t_lock_cmd();
      t_mce();
      t_parity();
      t_power();
      t_thermal();
      t_bus_reset();
      final_report();
   end

   initial begin
      repeat (5000) @(posedge i_ref_clk);
      err_count++;
      final_report();
   end
endmodule // tb_top
